// *** lths_pkg.sv ***
// Constants and types for the logical track head select block
package lths_pkg;
  localparam int CYL_W          = 16;
  localparam int TRK_W          = 16;
  localparam int POS_W          = 9;
  localparam int HEAD_W         = 4;
  localparam int FIX_W          = 5;
  localparam int NUM_HEADS      = 12;
  localparam int NUM_FIXED      = 30;
  localparam int HEADS_PER_POS  = 6;
  localparam int ACCESS_POS     = 350;
  localparam int PHYS_TRK_LAST  = 699;
  localparam logic [TRK_W-1:0] TRK_MAX        = 16'h000B;
  localparam logic [CYL_W-1:0] CYL_MAX_TWO    = 16'h015C;
  localparam logic [CYL_W-1:0] CYL_MAX_FOUR   = 16'h02B9;
  localparam logic [CYL_W-1:0] CYL_FIX_FIRST  = 16'h0001;
  localparam logic [CYL_W-1:0] CYL_FIX_LAST   = 16'h0005;
  localparam int FULL_TRACK_BYTES = 8368;
  localparam logic [13:0] TRK_BYTES_MAX = 14'h20B0;
  localparam int SEEK_HOME_NS   = 1000;
  localparam int CLK_NS         = 25;
  localparam int SEEK_HOME_CYC  = SEEK_HOME_NS / CLK_NS;
  typedef enum logic [1:0] {
    LTHS_MOD_NONE,
    LTHS_MOD_TWO,
    LTHS_MOD_FOUR,
    LTHS_MOD_FIXED
  } lths_mod_t;
endpackage

// *** lths_addr_map.sv ***
// Combinational translation of a track address word into a head choice
`timescale 1ns/1ps
module lths_addr_map
  import lths_pkg::*;
(
  input  wire lths_mod_t         modKind,
  input  wire logic [CYL_W-1:0]  cylinderField,
  input  wire logic [TRK_W-1:0]  trackInCylinderField,
  output logic                   addrOk,
  output logic                   useFixed,
  output logic [POS_W-1:0]       accessPos,
  output logic [HEAD_W-1:0]      headNum,
  output logic [FIX_W-1:0]       fixedNum,
  output logic                   oddTrack
);
  logic [CYL_W-1:0] cylMax;
  logic [CYL_W-1:0] cylOff;
  logic [3:0]       trkHalf;

  always_comb begin
    cylMax  = (modKind == LTHS_MOD_TWO) ? CYL_MAX_TWO : CYL_MAX_FOUR;
    trkHalf = trackInCylinderField[4:1];
    cylOff  = cylinderField - CYL_FIX_FIRST;
    addrOk  = (modKind != LTHS_MOD_NONE) && (cylinderField <= cylMax) &&
              (trackInCylinderField <= TRK_MAX);
    useFixed = (modKind == LTHS_MOD_FIXED) &&
               (cylinderField >= CYL_FIX_FIRST) &&
               (cylinderField <= CYL_FIX_LAST);
    oddTrack = trackInCylinderField[0];
    fixedNum = FIX_W'(cylOff[2:0] * 3'h6) + FIX_W'(trkHalf);
    if (modKind == LTHS_MOD_TWO) begin
      accessPos = cylinderField[POS_W-1:0];
      headNum   = trkHalf;
    end else begin
      accessPos = cylinderField[POS_W:1];
      headNum   = trkHalf + (cylinderField[0] ? 4'h6 : 4'h0);
    end
  end
endmodule

// *** lths_onehot.sv ***
// One-hot decoder for head or element enables
`timescale 1ns/1ps
module lths_onehot #(
  parameter int N  = 12,
  parameter int IW = 4
) (
  input  wire logic [IW-1:0] idx,
  input  wire logic          en,
  output logic [N-1:0]       sel
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_dec
      assign sel[i] = en && (idx == IW'(i));
    end
  endgenerate
endmodule

// *** lths_track_select.sv ***
// Track address translation, head selection and write protect
//
// How it works
// - Address is cylinder word then track word
// - Track word is logical track, derive head
// - Head n serves logical tracks 2n, 2n+1
// - Six heads per position form one cylinder
// - 350 positions, outer/inner head track ranges
// - At most one head or element enabled
// - Two-disk: user cylinders 0 to 348
// - Four-disk: heads 0-5 even, 6-11 odd
// - Four-disk: user cylinders 0 to 697
// - Fixed variant: cylinders 1-5 on 30 elements
// - Cylinders 1-5 auto select fixed element
// - Other fixed-variant cylinders map as four-disk
// - Read-only module lights read-only status
// - Write under read-only refused, interrupt raised
// - Servo surface never reachable by commands
// - Full track write capped at 8368 bytes
// - Report module size bits in sense
// - After load, seek track 0, then ready
`timescale 1ns/1ps
module lths_track_select
  import lths_pkg::*;
#(
  parameter int SEEK_CYC = SEEK_HOME_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  modLoaded,
  input  wire logic                  modReadOnlyIn,
  input  wire logic [1:0]            modSizeIn,
  input  wire logic                  cmdValid,
  input  wire logic                  cmdWrite,
  input  wire logic [31:0]           trackAddressWord,
  input  wire logic                  dataByteStb,
  input  wire logic                  cmdEnd,
  output logic                       ready_r,
  output logic                       readOnly_r,
  output logic                       readOnlyLamp_r,
  output logic [1:0]                 modSize_r,
  output logic                       addrError_r,
  output logic                       writeRefused_r,
  output logic                       attnIrq_r,
  output logic                       overrun_r,
  output logic [POS_W-1:0]           accessPos_r,
  output logic [NUM_HEADS-1:0]       headSel_r,
  output logic [NUM_FIXED-1:0]       fixedSel_r,
  output logic                       oddTrack_r,
  output logic                       writeGate_r
);
  // Load, read-only and size pin inputs pass two flip-flops before use
  logic [1:0] loadSync1;
  logic [1:0] loadSync2;
  logic [1:0] sizeSync1;
  logic [1:0] sizeSync2;
  logic       loadedPrev;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loadSync1 <= 2'h0;
      loadSync2 <= 2'h0;
      sizeSync1 <= 2'h0;
      sizeSync2 <= 2'h0;
    end else begin
      loadSync1 <= {modReadOnlyIn, modLoaded};
      loadSync2 <= loadSync1;
      sizeSync1 <= modSizeIn;
      sizeSync2 <= sizeSync1;
    end
  end

  wire logic loadedS = loadSync2[0];
  wire logic roS     = loadSync2[1];

  typedef enum logic [1:0] {
    LTHS_ST_IDLE,
    LTHS_ST_HOME,
    LTHS_ST_READY
  } lths_st_t;

  lths_st_t   st_r;
  logic [15:0] seekCnt_r;
  lths_mod_t  modKind_r;

  // Load sequence: home to track 0, then ready
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r      <= LTHS_ST_IDLE;
      seekCnt_r <= 16'h0;
      ready_r   <= 1'b0;
    end else begin
      unique case (st_r)
        LTHS_ST_IDLE: begin
          ready_r <= 1'b0;
          if (loadedS && !loadedPrev) begin
            st_r      <= LTHS_ST_HOME;
            seekCnt_r <= 16'(SEEK_CYC - 1);
          end
        end
        LTHS_ST_HOME: begin
          if (!loadedS) begin
            st_r <= LTHS_ST_IDLE;
          end else if (seekCnt_r == 16'h0) begin
            st_r    <= LTHS_ST_READY;
            ready_r <= 1'b1;
          end else begin
            seekCnt_r <= seekCnt_r - 16'h1;
          end
        end
        LTHS_ST_READY: begin
          if (!loadedS) begin
            st_r    <= LTHS_ST_IDLE;
            ready_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Module identity and read-only taken at load, held until unload
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loadedPrev     <= 1'b0;
      readOnly_r     <= 1'b0;
      readOnlyLamp_r <= 1'b0;
      modSize_r      <= 2'h0;
      modKind_r      <= LTHS_MOD_NONE;
    end else begin
      loadedPrev <= loadedS;
      if (!loadedS) begin
        readOnly_r     <= 1'b0;
        readOnlyLamp_r <= 1'b0;
        modSize_r      <= 2'h0;
        modKind_r      <= LTHS_MOD_NONE;
      end else if (!loadedPrev) begin
        readOnly_r     <= roS;
        readOnlyLamp_r <= roS;
        modSize_r      <= sizeSync2;
        modKind_r      <= lths_mod_t'(sizeSync2);
      end
    end
  end

  logic              addrOk;
  logic              useFixed;
  logic [POS_W-1:0]  mapPos;
  logic [HEAD_W-1:0] mapHead;
  logic [FIX_W-1:0]  mapFix;
  logic              mapOdd;

  // Upper word is cylinder field, lower word track field
  lths_addr_map u_map (
    .modKind              (modKind_r),
    .cylinderField        (trackAddressWord[31:16]),
    .trackInCylinderField (trackAddressWord[15:0]),
    .addrOk               (addrOk),
    .useFixed             (useFixed),
    .accessPos            (mapPos),
    .headNum              (mapHead),
    .fixedNum             (mapFix),
    .oddTrack             (mapOdd)
  );

  logic [NUM_HEADS-1:0] headDec;
  logic [NUM_FIXED-1:0] fixDec;
  logic                 take;
  logic                 accept;

  assign take   = cmdValid && ready_r;
  assign accept = take && addrOk && !(cmdWrite && readOnly_r);

  // At most one decoder enabled; servo read head has no select line
  lths_onehot #(.N(NUM_HEADS), .IW(HEAD_W)) u_head (
    .idx (mapHead),
    .en  (addrOk && !useFixed),
    .sel (headDec)
  );
  lths_onehot #(.N(NUM_FIXED), .IW(FIX_W)) u_fix (
    .idx (mapFix),
    .en  (addrOk && useFixed),
    .sel (fixDec)
  );

  logic [13:0] byteCnt_r;
  logic        active_r;
  logic        fullStop;

  assign fullStop = writeGate_r && dataByteStb &&
                    (byteCnt_r == TRK_BYTES_MAX);

  // Selection held for the command; a refused write selects nothing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      accessPos_r <= '0;
      headSel_r   <= '0;
      fixedSel_r  <= '0;
      oddTrack_r  <= 1'b0;
      writeGate_r <= 1'b0;
      active_r    <= 1'b0;
    end else if (take) begin
      active_r    <= accept;
      headSel_r   <= accept ? headDec : '0;
      fixedSel_r  <= accept ? fixDec : '0;
      writeGate_r <= accept && cmdWrite;
      oddTrack_r  <= mapOdd;
      if (accept && !useFixed) begin
        accessPos_r <= mapPos;
      end
    end else if (cmdEnd || !ready_r || fullStop) begin
      headSel_r   <= '0;
      fixedSel_r  <= '0;
      writeGate_r <= 1'b0;
      active_r    <= 1'b0;
      // Arm is parked at track 0 whenever the drive is not ready
      if (!ready_r) begin
        accessPos_r <= '0;
      end
    end
  end

  // Status pulses for rejected addresses and refused writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addrError_r    <= 1'b0;
      writeRefused_r <= 1'b0;
      attnIrq_r      <= 1'b0;
    end else begin
      addrError_r    <= take && !addrOk;
      writeRefused_r <= take && addrOk && cmdWrite && readOnly_r;
      attnIrq_r      <= take && addrOk && cmdWrite && readOnly_r;
    end
  end

  // Count written bytes; the write gate closes on a byte past a full track
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      byteCnt_r <= 14'h0;
      overrun_r <= 1'b0;
    end else if (take) begin
      // An excess strobe beside a new command still flags the old one
      byteCnt_r <= 14'h0;
      overrun_r <= fullStop;
    end else if (dataByteStb && writeGate_r) begin
      if (byteCnt_r != TRK_BYTES_MAX) begin
        byteCnt_r <= byteCnt_r + 14'h1;
      end else begin
        overrun_r <= 1'b1;
      end
    end
  end

  a_one_head: assert property (@(posedge mclk) disable iff (rst)
    $onehot0({headSel_r, fixedSel_r}))
    else $error("more than one head or element enabled");

  a_ro_refuse: assert property (@(posedge mclk) disable iff (rst)
    (take && addrOk && cmdWrite && readOnly_r) |=>
      (attnIrq_r && !writeGate_r && headSel_r == '0))
    else $error("read-only write not refused");

  a_bad_addr: assert property (@(posedge mclk) disable iff (rst)
    (take && !addrOk) |=> (addrError_r && headSel_r == '0 &&
                           fixedSel_r == '0))
    else $error("bad address selected a head");

  a_fixed_pick: assert property (@(posedge mclk) disable iff (rst)
    (accept && useFixed) |=> (fixedSel_r != '0 && headSel_r == '0))
    else $error("fixed cylinder did not pick an element");

  a_even_odd: assert property (@(posedge mclk) disable iff (rst)
    (accept && !useFixed && modKind_r == LTHS_MOD_FOUR) |=>
      ((headSel_r[11:6] != 6'h0) == $past(trackAddressWord[16])))
    else $error("head bank does not match cylinder parity");

  a_home_ready: assert property (@(posedge mclk) disable iff (rst)
    $rose(ready_r) |-> $past(st_r) == LTHS_ST_HOME)
    else $error("ready without homing");

  a_ro_lamp: assert property (@(posedge mclk) disable iff (rst)
    readOnly_r == readOnlyLamp_r)
    else $error("read-only lamp disagrees with status");

  a_ro_load: assert property (@(posedge mclk) disable iff (rst)
    (loadedS && !loadedPrev) |=>
      (readOnly_r == $past(roS) && readOnlyLamp_r == $past(roS)))
    else $error("read-only setting not taken at load");

  a_two_range: assert property (@(posedge mclk) disable iff (rst)
    (take && modKind_r == LTHS_MOD_TWO &&
     trackAddressWord[31:16] > CYL_MAX_TWO) |=> addrError_r)
    else $error("two-disk cylinder above limit accepted");

  a_track_cap: assert property (@(posedge mclk) disable iff (rst)
    byteCnt_r <= TRK_BYTES_MAX)
    else $error("track byte count beyond full track");
endmodule

// *** lths_ctrl_model.sv ***
// Storage control model that sends track commands to the drive
`timescale 1ns/1ps
module lths_ctrl_model (
  input  wire logic        mclk,
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [31:0]      trackAddressWord,
  output logic             dataByteStb,
  output logic             cmdEnd
);
  initial begin
    cmdValid = 1'h0;
    cmdWrite = 1'h0;
    dataByteStb = 1'h0;
    cmdEnd = 1'h0;
    trackAddressWord = 32'h5A5AA5A5;
  end
  // Address and qualifier scramble once dropped, so a stale word never helps
  task automatic issue(input logic w, input logic [31:0] addr);
    @(negedge mclk);
    cmdValid = 1'h1;
    cmdWrite = w;
    trackAddressWord = addr;
    @(negedge mclk);
    cmdValid = 1'h0;
    cmdWrite = ~w;
    trackAddressWord = ~addr;
  endtask
  task automatic endCmd;
    @(negedge mclk);
    cmdEnd = 1'h1;
    @(negedge mclk);
    cmdEnd = 1'h0;
  endtask
  task automatic bytes(input int n);
    @(negedge mclk);
    dataByteStb = 1'h1;
    repeat (n) @(negedge mclk);
    dataByteStb = 1'h0;
  endtask
endmodule

// *** lths_track_select_test.sv ***
// Self-checking bench for the track address head select block
`timescale 1ns/1ps
module lths_track_select_test;
  import lths_pkg::*;
  logic                 mclk, rst, modLoaded, modReadOnlyIn;
  logic [1:0]           modSizeIn, modSize_r;
  logic                 cmdValid, cmdWrite, dataByteStb, cmdEnd;
  logic [31:0]          trackAddressWord;
  logic                 ready_r, readOnly_r, readOnlyLamp_r, addrError_r;
  logic                 writeRefused_r, attnIrq_r, overrun_r, oddTrack_r;
  logic                 writeGate_r, ro;
  logic [POS_W-1:0]     accessPos_r;
  logic [NUM_HEADS-1:0] headSel_r;
  logic [NUM_FIXED-1:0] fixedSel_r;
  integer               error_cnt = 0, samples_checked = 0, seed = 32'hA2E8;
  int                   kind, c, t;
  int edgeCyl[10] = '{348, 349, 697, 698, 0, 1, 5, 6, 3, 2};
  int edgeTrk[10] = '{11, 12, 0, 11, 1, 10, 11, 0, 5, 7};

  // Short homing count keeps each load to a handful of cycles
  lths_track_select #(.SEEK_CYC(2)) uut (.mclk, .rst, .modLoaded,
    .modReadOnlyIn, .modSizeIn, .cmdValid, .cmdWrite, .trackAddressWord,
    .dataByteStb, .cmdEnd, .ready_r, .readOnly_r, .readOnlyLamp_r,
    .modSize_r, .addrError_r, .writeRefused_r, .attnIrq_r, .overrun_r,
    .accessPos_r, .headSel_r, .fixedSel_r, .oddTrack_r, .writeGate_r);
  lths_ctrl_model ctl (.mclk, .cmdValid, .cmdWrite, .trackAddressWord,
    .dataByteStb, .cmdEnd);

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic load(input int k, input logic r);
    int n;
    @(negedge mclk);
    modLoaded = 1'h0;
    repeat (6) @(negedge mclk);
    chk("sizeIdle", 0, modSize_r);
    modSizeIn = k[1:0];
    modReadOnlyIn = r;
    modLoaded = 1'h1;
    n = 0;
    while (ready_r !== 1'h1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk("ready", 1, ready_r);
    chk("homePos", 0, accessPos_r);
    chk("modSize", k, modSize_r);
    chk("readOnly", r, readOnly_r);
    chk("lamp", r, readOnlyLamp_r);
  endtask

  // Behavioural expectation of one command, then compare every result
  task automatic cmd(input int k, input logic r, input logic w,
                     input int cyl, input int trk);
    logic ae, rf, ir, ok, fx, sel;
    int pos, hd, fi;
    ctl.issue(w, {cyl[15:0], trk[15:0]});
    ae = addrError_r;
    rf = writeRefused_r;
    ir = attnIrq_r;
    @(negedge mclk);
    ae |= addrError_r;
    rf |= writeRefused_r;
    ir |= attnIrq_r;
    ok = k != 0 && trk <= 11 && cyl <= (k == 1 ? 348 : 697);
    fx = k == 3 && cyl >= 1 && cyl <= 5;
    pos = k == 1 ? cyl : cyl / 2;
    hd = trk / 2 + ((k != 1 && cyl % 2 == 1) ? 6 : 0);
    fi = fx ? (cyl - 1) * 6 + trk / 2 : 0;
    sel = ok && !(w && r);
    chk("addrError", !ok, ae);
    chk("refused", ok && w && r, rf);
    chk("attn", ok && w && r, ir);
    chk("headSel", (sel && !fx) ? 1 << hd : 0, headSel_r);
    chk("fixedSel", (sel && fx) ? 1 << fi : 0, fixedSel_r);
    chk("writeGate", sel && w, writeGate_r);
    if (sel) chk("odd", trk % 2, oddTrack_r);
    if (sel && !fx) chk("accessPos", pos, accessPos_r);
  endtask

  // Roughly 9100 cycles expected; the limit leaves ample slack
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    rst = 1'h1;
    modLoaded = 1'h0;
    modReadOnlyIn = 1'h0;
    modSizeIn = 2'h0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'h0;
    for (int m = 0; m < 4; m++) begin
      kind = m == 0 ? 2 : m;
      ro = m == 0;
      load(kind, ro);
      for (int i = 0; i < 40; i++) begin
        c = i < 10 ? edgeCyl[i] : {$random(seed)} % 720;
        t = i < 10 ? edgeTrk[i] : {$random(seed)} % 14;
        cmd(kind, ro, 1'({$random(seed)} % 2), c, t);
        if (i % 2 == 1) begin
          ctl.endCmd();
          chk("released", 0, headSel_r | fixedSel_r);
        end
      end
      $display("Test size %0d read-only %0d done", kind, ro);
    end
    cmd(3, 1'h0, 1'h1, 10, 4);
    ctl.bytes(8368);
    chk("overrun", 0, overrun_r);
    chk("gateHeld", 1, writeGate_r);
    ctl.bytes(1);
    @(negedge mclk);
    chk("overrun", 1, overrun_r);
    chk("gateDrop", 0, writeGate_r);
    $display("Test full track write limit done");
    load(0, 1'h0);
    cmd(0, 1'h0, 1'h0, 3, 5);
    cmd(0, 1'h0, 1'h1, 0, 0);
    $display("Test no module done");
    report_and_stop();
  end
endmodule
